/* File: test/sbi_top_tb.sv */
// Self-checking testbench for the slip buffer interrupt logic.
// Assumes the design's byte-wide register port and same-clock buffer levels and strobes.
`timescale 1ns/10ps
`include "sbi_consts.svh"

module sbi_top_tb
  import sbi_pkg::*;
;
  logic sys_clk;
  logic sys_rst;
  logic [15:0] reg_addr;
  sbi_byte_t reg_wdata;
  sbi_byte_t reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic [3:0] lv;
  logic [3:0] st;
  logic [3:0] pulse;
  logic slip_irq;
  int n_errors;
  int num_checks;
  // Flag pattern each event kind should leave: rx under, rx over, tx under, tx over
  sbi_byte_t ev_flags [4] = '{8'h03, 8'h05, 8'h60, 8'hA0};

  sbi_top #(.ADDR_W(16)) uut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .rx_buf_empty(lv[0]),
    .rx_buf_full(lv[1]),
    .rx_buf_rd(st[0]),
    .rx_buf_wr(st[1]),
    .rx_replay_frame(pulse[0]),
    .rx_drop_frame(pulse[1]),
    .tx_buf_empty(lv[2]),
    .tx_buf_full(lv[3]),
    .tx_buf_rd(st[2]),
    .tx_buf_wr(st[3]),
    .tx_replay_frame(pulse[2]),
    .tx_drop_frame(pulse[3]),
    .slip_irq(slip_irq)
  );

  // Free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Compare one value and count it
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe; the slave never stalls
  task automatic wr(input logic [15:0] a, input sbi_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // One-cycle read strobe; data stand only in the following cycle
  task automatic rd(input logic [15:0] a, input sbi_byte_t exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask

  // One buffer access with the levels given in lvl; k picks the buffer and kind
  task automatic ev(input int k, input logic [3:0] lvl);
    @(posedge sys_clk);
    lv <= lvl;
    st <= 4'h1 << k;
    @(posedge sys_clk);
    lv <= 4'h0;
    st <= 4'h0;
    #1;
    chk("frame pulse", {4'h0, pulse}, {4'h0, lvl});
    // Step off the edge so callers see settled flags and request
    @(posedge sys_clk);
    #1;
  endtask

  // Verdict; also reached by the watchdog
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the tests need well under its 5000 cycles
  initial
  begin
    #200000;
    n_errors++;
    test_done();
  end

  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lv = 4'h0;
    st = 4'h0;
    n_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values, reserved gate bits, read-only flags, unmapped address
    rd(16'h0B08, 8'h00, "flags reset");
    rd(16'h0B09, 8'h00, "gates reset");
    wr(16'h0B09, 8'hFF);
    rd(16'h0B09, 8'hE7, "gates all ones");
    chk("irq no flags", {7'h00, slip_irq}, 8'h00);
    rd(16'h0B0A, 8'h00, "unmapped read");
    wr(16'h0B08, 8'hFF);
    rd(16'h0B08, 8'h00, "flags after write");
    wr(16'h0B09, 8'h00);
    $display("test registers done");
    // Each slip kind: pulse, flags, gating of the interrupt, clear on read
    for (int k = 0; k < 4; k++)
    begin
      ev(k, 4'h1 << k);
      chk("irq gated off", {7'h00, slip_irq}, 8'h00);
      wr(16'h0B09, ~ev_flags[k] & 8'hE7);
      #1;
      chk("irq other gates", {7'h00, slip_irq}, 8'h00);
      wr(16'h0B09, ev_flags[k]);
      #1;
      chk("irq gated on", {7'h00, slip_irq}, 8'h01);
      rd(16'h0B08, ev_flags[k], "flags after slip");
      chk("irq after clear", {7'h00, slip_irq}, 8'h00);
      rd(16'h0B08, 8'h00, "flags second read");
      wr(16'h0B09, 8'h00);
    end
    $display("test slip events done");
    // A slip landing in the cycle of a status read keeps its bits; the read shows the old value
    fork
      ev(0, 4'h1);
      begin
        @(posedge sys_clk);
        rd(16'h0B08, 8'h00, "flags read beside slip");
      end
    join
    rd(16'h0B08, 8'h03, "flags kept by slip");
    rd(16'h0B08, 8'h00, "flags cleared after slip");
    $display("test set beats clear done");
    // Accesses without empty or full levels must not slip
    wr(16'h0B09, 8'hE7);
    for (int k = 0; k < 4; k++)
      ev(k, 4'h0);
    chk("irq no slip", {7'h00, slip_irq}, 8'h00);
    rd(16'h0B08, 8'h00, "flags no slip");
    $display("test plain access done");
    // Mid-run reset with a flag and all gates set must clear both
    ev(0, 4'h1);
    chk("irq before reset", {7'h00, slip_irq}, 8'h01);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk("irq after reset", {7'h00, slip_irq}, 8'h00);
    rd(16'h0B08, 8'h00, "flags after reset");
    rd(16'h0B09, 8'h00, "gates after reset");
    $display("test mid-run reset done");
    test_done();
  end
endmodule

/* File: verilog/sbi_consts.svh */
// Register map, field positions and reset values for the slip buffer interrupt logic.
// Assumes a byte-wide register port and the framer's single system clock.
// Behaviour
// - Receive underflow sets status bit 1
// - Read of empty buffer replays one frame
// - Write into full buffer drops one frame
// - Receive underflow or overflow sets bit 0
// - Status flags reset zero, clear on read
// - Gate bit 7 enables transmit overflow interrupt
// - Gate bit 6 enables transmit underflow interrupt
// - Gate bit 5 enables transmit slip interrupt
// - Receive overflow sets status bit 2
// - Transmit underflow bit 6, slip bit 5
// - Gate bits 2,1,0 enable receive interrupts
`ifndef SBI_CONSTS_SVH
`define SBI_CONSTS_SVH

`define SBI_FLAGS_ADDR 16'h0B08
`define SBI_GATES_ADDR 16'h0B09
`define SBI_REG_RST 8'h00
`define SBI_REG_MASK 8'hE7
`define SBI_BIT_RX_SLIP 0
`define SBI_BIT_RX_UNDER 1
`define SBI_BIT_RX_OVER 2
`define SBI_BIT_TX_SLIP 5
`define SBI_BIT_TX_UNDER 6
`define SBI_BIT_TX_OVER 7
`define SBI_MIN_ADDR_W 12

`endif

/* File: verilog/sbi_pkg.sv */
// Types shared by the slip buffer interrupt logic.
// Assumes the constants header is included by each design file.
package sbi_pkg;

  typedef logic [7:0] sbi_byte_t;

  // Index of each elastic buffer in the per-direction arrays
  typedef enum logic [0:0]
  {
    SBI_DIR_RX = 1'b0,
    SBI_DIR_TX = 1'b1
  } sbi_dir_t;

endpackage

/* File: verilog/sbi_slip_detect.sv */
// Underflow and overflow detector for one elastic buffer.
// Assumes buffer level flags and access strobes come from logic on sys_clk.
`timescale 1ns/10ps
`include "sbi_consts.svh"

module sbi_slip_detect
  import sbi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic buf_empty,
  input wire logic buf_full,
  input wire logic buf_rd,
  input wire logic buf_wr,
  output logic replay_req,
  output logic drop_req
);

  logic replay_r;
  logic replay_nxt;
  logic drop_r;
  logic drop_nxt;

  // Slip commands for the buffer datapath
  always_comb
  begin
    replay_nxt = buf_rd && buf_empty;
    drop_nxt = buf_wr && buf_full;
  end

  // Registered so the commands are clean pulses, high one cycle per slipping access
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      replay_r <= 1'b0;
      drop_r <= 1'b0;
    end
    else
    begin
      replay_r <= replay_nxt;
      drop_r <= drop_nxt;
    end
  end

  assign replay_req = replay_r;
  assign drop_req = drop_r;

  default clocking sd_cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // replay check; back-to-back attempts hold replay_req high one cycle per attempt, as one longer pulse
  AST_REPLAY_ON_EMPTY: assert property ((buf_rd && buf_empty) |=> replay_req)
    else $error("Read of empty buffer did not replay a frame");

  AST_REPLAY_CAUSE: assert property (replay_req |-> $past(buf_rd && buf_empty))
    else $error("Frame replayed without a read of an empty buffer");

  AST_DROP_ON_FULL: assert property (drop_req |-> $past(buf_wr) && $past(buf_full))
    else $error("Frame dropped without a write into a full buffer");

  AST_DROP_FORWARD: assert property ((buf_wr && buf_full) |=> drop_req)
    else $error("Write into full buffer did not drop a frame");

endmodule

/* File: verilog/sbi_top.sv */
// Slip buffer interrupt status, enable and request logic for the receive and transmit elastic buffers.
// Assumes a byte-wide register port on sys_clk and buffer strobes from logic on sys_clk.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "sbi_consts.svh"

module sbi_top
  import sbi_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_buf_empty,
  input wire logic rx_buf_full,
  input wire logic rx_buf_rd,
  input wire logic rx_buf_wr,
  output logic rx_replay_frame,
  output logic rx_drop_frame,
  input wire logic tx_buf_empty,
  input wire logic tx_buf_full,
  input wire logic tx_buf_rd,
  input wire logic tx_buf_wr,
  output logic tx_replay_frame,
  output logic tx_drop_frame,
  output logic slip_irq
);

  // The map needs twelve address bits to reach both registers
  if (ADDR_W < `SBI_MIN_ADDR_W)
  begin : g_addr_check
    $error("sbi_top: ADDR_W too narrow for the register map");
  end

  localparam logic [ADDR_W-1:0] FLAGS_ADDR = ADDR_W'(`SBI_FLAGS_ADDR);
  localparam logic [ADDR_W-1:0] GATES_ADDR = ADDR_W'(`SBI_GATES_ADDR);

  logic [1:0] buf_empty;
  logic [1:0] buf_full;
  logic [1:0] buf_rd;
  logic [1:0] buf_wr;
  logic [1:0] under_evt;
  logic [1:0] over_evt;
  logic flags_hit;
  logic gates_hit;
  sbi_byte_t flags_r;
  sbi_byte_t flags_nxt;
  sbi_byte_t gates_r;
  sbi_byte_t gates_nxt;
  sbi_byte_t rdata_r;
  sbi_byte_t rdata_nxt;
  logic irq_r;
  logic irq_nxt;

  // Gather both buffers into per-direction arrays
  assign buf_empty = {tx_buf_empty, rx_buf_empty};
  assign buf_full = {tx_buf_full, rx_buf_full};
  assign buf_rd = {tx_buf_rd, rx_buf_rd};
  assign buf_wr = {tx_buf_wr, rx_buf_wr};

  // One slip detector per elastic buffer
  for (genvar d = 0; d < 2; d++)
  begin : g_dir
    sbi_slip_detect u_detect
    (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .buf_empty(buf_empty[d]),
      .buf_full(buf_full[d]),
      .buf_rd(buf_rd[d]),
      .buf_wr(buf_wr[d]),
      .replay_req(under_evt[d]),
      .drop_req(over_evt[d])
    );
  end

  assign rx_replay_frame = under_evt[SBI_DIR_RX];
  assign rx_drop_frame = over_evt[SBI_DIR_RX];
  assign tx_replay_frame = under_evt[SBI_DIR_TX];
  assign tx_drop_frame = over_evt[SBI_DIR_TX];

  // Address decode; anything else reads zero and ignores writes
  assign flags_hit = (reg_addr == FLAGS_ADDR);
  assign gates_hit = (reg_addr == GATES_ADDR);

  // Sticky status flags: clear on read, then events set, so an event in the read cycle survives
  always_comb
  begin
    flags_nxt = flags_r;
    if (reg_rd && flags_hit)
    begin
      flags_nxt = `SBI_REG_RST;
    end
    if (under_evt[SBI_DIR_RX])
    begin
      flags_nxt[`SBI_BIT_RX_UNDER] = 1'b1;
    end
    if (over_evt[SBI_DIR_RX])
    begin
      flags_nxt[`SBI_BIT_RX_OVER] = 1'b1;
    end
    if (under_evt[SBI_DIR_RX] || over_evt[SBI_DIR_RX])
    begin
      flags_nxt[`SBI_BIT_RX_SLIP] = 1'b1;
    end
    if (under_evt[SBI_DIR_TX])
    begin
      flags_nxt[`SBI_BIT_TX_UNDER] = 1'b1;
    end
    if (over_evt[SBI_DIR_TX])
    begin
      flags_nxt[`SBI_BIT_TX_OVER] = 1'b1;
    end
    if (under_evt[SBI_DIR_TX] || over_evt[SBI_DIR_TX])
    begin
      flags_nxt[`SBI_BIT_TX_SLIP] = 1'b1;
    end
  end

  // Gate register; reserved bits never store, so they read back as zero
  always_comb
  begin
    gates_nxt = gates_r;
    if (reg_wr && gates_hit)
    begin
      gates_nxt = reg_wdata & `SBI_REG_MASK;
    end
  end

  // Read data stands for exactly one cycle after the read strobe
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_rd && flags_hit)
    begin
      rdata_nxt = flags_r & `SBI_REG_MASK;
    end
    else if (reg_rd && gates_hit)
    begin
      rdata_nxt = gates_r;
    end
  end

  always_comb
  begin
    // Computed from next values so the request tracks the registered flags without lag
    irq_nxt = |(flags_nxt & gates_nxt);
  end

  // Register stage for status, gates, read data and request
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      flags_r <= `SBI_REG_RST;
      gates_r <= `SBI_REG_RST;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      gates_r <= gates_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign slip_irq = irq_r;

  default clocking top_cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  AST_RX_UNDER_SET: assert property (under_evt[0] |=> flags_r[1])
    else $error("Receive underflow did not set the underflow flag");

  AST_RX_SLIP_SET: assert property ((under_evt[0] || over_evt[0]) |=> flags_r[0])
    else $error("Receive slip did not set the slip flag");

  AST_RX_OVER_SET: assert property (over_evt[0] |=> flags_r[2])
    else $error("Receive overflow did not set the overflow flag");

  AST_TX_UNDER_SET: assert property (under_evt[1] |=> (flags_r[6] && flags_r[5]))
    else $error("Transmit underflow did not set bits 6 and 5");

  AST_TX_OVER_SET: assert property (over_evt[1] |=> (flags_r[7] && flags_r[5]))
    else $error("Transmit overflow did not set bits 7 and 5");

  AST_CLEAR_ON_READ: assert property ((reg_rd && flags_hit && under_evt == 2'b00 && over_evt == 2'b00)
    |=> flags_r == 8'h00 && reg_rdata == ($past(flags_r) & 8'hE7))
    else $error("Status read did not return and clear the flags");

  AST_FLAGS_HOLD: assert property ((!reg_rd && under_evt == 2'b00 && over_evt == 2'b00) |=> $stable(flags_r))
    else $error("Status flags changed without an event or read");

  AST_GATE_TX_OVER: assert property ((reg_wr && gates_hit) |=> gates_r[7] == $past(reg_wdata[7]))
    else $error("Transmit overflow gate did not take the written value");

  AST_GATE_WRITE: assert property ((reg_wr && gates_hit) |=> gates_r[6:5] == $past(reg_wdata[6:5])
    && gates_r[2:0] == $past(reg_wdata[2:0]))
    else $error("Gate register did not take the written value");

  AST_GATES_RESERVED: assert property (gates_r[4:3] == 2'b00 && flags_r[4:3] == 2'b00)
    else $error("Reserved bits are not zero");

  AST_IRQ_LEVEL: assert property (slip_irq == |(flags_r & gates_r))
    else $error("Interrupt request does not match gated flags");

  // Main scenarios
  COV_RX_UNDER_IRQ: cover property (under_evt[0] ##1 slip_irq);
  COV_TX_DROP: cover property (over_evt[1] ##1 flags_r[7]);
  COV_READ_CLEARS: cover property (flags_r != 8'h00 ##0 (reg_rd && flags_hit) ##1 flags_r == 8'h00);
  COV_SET_IN_READ: cover property ((reg_rd && flags_hit && under_evt[0]) ##1 flags_r[1]);

endmodule
